/* File: src/arsa_map.svh */
// arsa_map.svh: offsets, fields, reset values and fixed figures.
// assumes: included by bare name, before the package and the modules.
`ifndef ARSA_MAP_SVH
`define ARSA_MAP_SVH
// ==========================================================================
// widths and depths
`define ARSA_IDX_W 7
`define ARSA_DEPTH 128
`define ARSA_DATA_W 64
`define ARSA_INT_W 65
`define ARSA_FLT_W 82
`define ARSA_PRD_N 64
`define ARSA_BRR_N 8
`define ARSA_CNT_W 16
`define ARSA_LEG_LO 7'h08
`define ARSA_LEG_HI 7'h1F
`define ARSA_INT_TAG_BIT 64
// ==========================================================================
// miscellaneous register set, eight entries
`define ARSA_APP_CTRL 7'h01
`define ARSA_APP_STAT 7'h02
`define ARSA_APP_IMPL 7'h03
`define ARSA_APP_SIZE 7'h08
// control word: mode 1:0, ignored 3:2, reserved above
`define ARSA_CTRL_RSV_MASK 82'h3FFFFFFFFFFFFFFFFFFF0
`define ARSA_MODE_RSV 2'h3
`define ARSA_MODE_RESET 2'h0
// ==========================================================================
// constant values and reset values
`define ARSA_FP_ZERO 82'h000000000000000000000
`define ARSA_FP_ONE 82'h0FFFF8000000000000000
`define ARSA_IP_RESET 64'h0000000000000000
`define ARSA_BUNDLE_LSBS 4
`endif

/* File: src/arsa_mem_if.sv */
// arsa_mem_if: write and read port between the top and a register array.
// assumes: one clock, one write and one read per cycle.
`include "arsa_map.svh"
interface arsa_mem_if #(parameter int W = 65);
    logic we;
    logic [`ARSA_IDX_W-1:0] waddr;
    logic [W-1:0] wdata;
    logic [`ARSA_IDX_W-1:0] raddr;
    logic [W-1:0] rdata;
    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: src/arsa_pkg.sv */
// arsa_pkg: types of the application register state block.
// assumes: arsa_map.svh is on the include path.
`include "arsa_map.svh"
package arsa_pkg;
    // ======================================================================
    // request target file
    typedef enum logic [2:0] {
        FILE_INT = 3'h0,
        FILE_FLT = 3'h1,
        FILE_PRD = 3'h2,
        FILE_BRR = 3'h3,
        FILE_IPR = 3'h4,
        FILE_APP = 3'h5
    } arsa_file_e;
    // fault reported to the exception logic
    typedef enum logic [1:0] {
        FLT_NONE = 2'h0,
        FLT_ILLOP = 2'h1,
        FLT_RESFLD = 2'h2
    } arsa_fault_e;
    // where the read answer comes from
    typedef enum logic [1:0] {
        SRC_SMALL = 2'h0,
        SRC_INT = 2'h1,
        SRC_FLT = 2'h2
    } arsa_src_e;
    // ======================================================================
    // whole state of the top module
    typedef struct packed {
        logic s1_valid;
        arsa_src_e s1_src;
        arsa_fault_e s1_fault;
        logic [`ARSA_FLT_W-1:0] s1_val;
        logic out_valid;
        logic [`ARSA_FLT_W-1:0] out_data;
        logic out_tag;
        logic out_fault_valid;
        arsa_fault_e out_fault;
        logic [`ARSA_PRD_N-1:0] pred;
        logic [`ARSA_BRR_N-1:0][`ARSA_DATA_W-1:0] br;
        logic [`ARSA_DATA_W-1:0] ip;
        logic [1:0] mode;
        logic [`ARSA_CNT_W-1:0] fault_count;
    } arsa_state_s;
endpackage

/* File: src/arsa_regmem.sv */
// arsa_regmem: 128-entry register array with registered read data.
// assumes: mclk shared with the owner; read sees the old entry on a
// same-address write in the same cycle.
`include "arsa_map.svh"
module arsa_regmem #(parameter int W = 65) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // array port
    arsa_mem_if.store port
);
    typedef struct packed {
        logic [`ARSA_DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rdata;
    } arsa_mem_s;
    arsa_mem_s st;
    arsa_mem_s next_st;
    // ======================================================================
    // array contents are not reset; only the read register is
    always_comb begin
        next_st = st;
        next_st.rdata = st.mem[port.raddr];
        if (port.we) begin
            next_st.mem[port.waddr] = port.wdata;
        end
        if (rst) begin
            next_st.rdata = '0;
        end
    end
    always_ff @(posedge mclk) begin
        st <= next_st;
    end
    assign port.rdata = st.rdata;
endmodule // arsa_regmem

/* File: src/arsa_regstate.sv */
// arsa_regstate: application register files and the access policy.
// assumes: requests come from pipeline logic on mclk, one per cycle;
// answers and faults appear two edges after the request is taken.
//
// Functional notes
// - reserved register access gives illegal-operation fault
// - ignored register reads zero, writes dropped
// - unimplemented set entries give reserved-field fault
// - reserved field bits always read zero
// - nonzero write to reserved field faults
// - ignored fields read zero, writes dropped
// - reserved encoding written gives reserved-field fault
// - read-only write faults, contents unchanged
// - 128 integer entries of 64 bits
// - 128 floating-point entries
// - 64 single-bit predicate registers
// - eight branch target registers
// - pointer holds bundle or legacy byte address
// - legacy requests reach only legacy-mapped entries
// - integer entry 0 reads zero, write faults
// - deferred exception tag beside integer data
// - float entries 0/1 constant, write faults
// - predicate 0 reads one, writes dropped
`include "arsa_map.svh"
module arsa_regstate (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // access request
    input wire logic req_valid,
    input wire logic req_write,
    input wire arsa_pkg::arsa_file_e req_file,
    input wire logic [`ARSA_IDX_W-1:0] req_index,
    input wire logic [`ARSA_FLT_W-1:0] req_wdata,
    input wire logic req_wtag,
    input wire logic req_legacy,
    // instruction pointer update
    input wire logic ip_load,
    input wire logic ip_legacy,
    input wire logic [`ARSA_DATA_W-1:0] ip_target,
    // answer and fault
    output logic rsp_valid,
    output logic [`ARSA_FLT_W-1:0] rsp_rdata,
    output logic rsp_tag,
    output logic fault_valid,
    output arsa_pkg::arsa_fault_e fault_code,
    output logic [`ARSA_DATA_W-1:0] ip_value
);
    arsa_pkg::arsa_state_s st;
    arsa_pkg::arsa_state_s next_st;
    arsa_pkg::arsa_fault_e fault;
    logic commit;
    arsa_mem_if #(.W(`ARSA_INT_W)) int_if ();
    arsa_mem_if #(.W(`ARSA_FLT_W)) flt_if ();

    // ======================================================================
    // access policy: which fault a request raises, if any
    function automatic arsa_pkg::arsa_fault_e access_fault(
        input arsa_pkg::arsa_file_e file,
        input logic [`ARSA_IDX_W-1:0] idx,
        input logic wr,
        input logic [`ARSA_FLT_W-1:0] wdata,
        input logic legacy
    );
        arsa_pkg::arsa_fault_e f;
        logic leg_ok;
        f = arsa_pkg::FLT_NONE;
        leg_ok = (file == arsa_pkg::FILE_INT || file == arsa_pkg::FILE_FLT) &&
                 idx >= `ARSA_LEG_LO && idx <= `ARSA_LEG_HI;
        case (file)
            arsa_pkg::FILE_INT: if (wr && idx == 7'h00) f = arsa_pkg::FLT_ILLOP;
            arsa_pkg::FILE_FLT: if (wr && idx < 7'h02) f = arsa_pkg::FLT_ILLOP;
            arsa_pkg::FILE_PRD: if (idx >= 7'(`ARSA_PRD_N)) f = arsa_pkg::FLT_ILLOP;
            arsa_pkg::FILE_BRR: if (idx >= 7'(`ARSA_BRR_N)) f = arsa_pkg::FLT_ILLOP;
            arsa_pkg::FILE_IPR: if (wr || idx != 7'h00) f = arsa_pkg::FLT_ILLOP;
            arsa_pkg::FILE_APP: begin
                if (idx >= `ARSA_APP_SIZE) begin
                    f = arsa_pkg::FLT_ILLOP;
                end else if (idx >= `ARSA_APP_IMPL) begin
                    f = arsa_pkg::FLT_RESFLD;
                end else if (wr && idx == `ARSA_APP_STAT) begin
                    f = arsa_pkg::FLT_ILLOP;
                end else if (wr && idx == `ARSA_APP_CTRL) begin
                    if ((wdata & `ARSA_CTRL_RSV_MASK) != '0) f = arsa_pkg::FLT_RESFLD;
                    if (wdata[1:0] == `ARSA_MODE_RSV) f = arsa_pkg::FLT_RESFLD;
                end
            end
            default: f = arsa_pkg::FLT_ILLOP;
        endcase
        // legacy code sees only its own entries
        if (legacy && !leg_ok) f = arsa_pkg::FLT_ILLOP;
        return f;
    endfunction

    // request decode; a fault blocks the request's write, but fault_count still counts it
    assign fault = access_fault(req_file, req_index, req_write, req_wdata, req_legacy);
    assign commit = req_valid && req_write && fault == arsa_pkg::FLT_NONE;

    // ======================================================================
    // big arrays: integer with tag bit on top, floating point
    assign int_if.we = commit && req_file == arsa_pkg::FILE_INT;
    assign int_if.waddr = req_index;
    assign int_if.wdata = {req_wtag, req_wdata[`ARSA_DATA_W-1:0]};
    assign int_if.raddr = req_index;
    assign flt_if.we = commit && req_file == arsa_pkg::FILE_FLT;
    assign flt_if.waddr = req_index;
    assign flt_if.wdata = req_wdata;
    assign flt_if.raddr = req_index;

    arsa_regmem #(.W(`ARSA_INT_W)) u_int_mem (
        .mclk(mclk),
        .rst(rst),
        .port(int_if.store)
    );
    arsa_regmem #(.W(`ARSA_FLT_W)) u_flt_mem (
        .mclk(mclk),
        .rst(rst),
        .port(flt_if.store)
    );

    // ======================================================================
    // next state: decode stage, answer stage, small registers
    always_comb begin
        next_st = st;
        // stage one: remember source and any small-register value
        next_st.s1_valid = req_valid;
        next_st.s1_fault = req_valid ? fault : arsa_pkg::FLT_NONE;
        next_st.s1_src = arsa_pkg::SRC_SMALL;
        next_st.s1_val = '0; // faulting reads return no data
        if (req_valid && !req_write && fault == arsa_pkg::FLT_NONE) begin
            case (req_file)
                arsa_pkg::FILE_INT: begin
                    // entry 0 is a constant zero, not an array word
                    if (req_index != 7'h00) next_st.s1_src = arsa_pkg::SRC_INT;
                end
                arsa_pkg::FILE_FLT: begin
                    if (req_index == 7'h00) next_st.s1_val = `ARSA_FP_ZERO;
                    else if (req_index == 7'h01) next_st.s1_val = `ARSA_FP_ONE;
                    else next_st.s1_src = arsa_pkg::SRC_FLT;
                end
                arsa_pkg::FILE_PRD: begin
                    next_st.s1_val[0] = (req_index == 7'h00) ? 1'b1 : st.pred[req_index[5:0]];
                end
                arsa_pkg::FILE_BRR: next_st.s1_val[63:0] = st.br[req_index[2:0]];
                arsa_pkg::FILE_IPR: next_st.s1_val[63:0] = st.ip;
                arsa_pkg::FILE_APP: begin
                    // ignored register and ignored/reserved bits stay zero
                    if (req_index == `ARSA_APP_CTRL) next_st.s1_val[1:0] = st.mode;
                    if (req_index == `ARSA_APP_STAT) next_st.s1_val[15:0] = st.fault_count;
                end
                default: next_st.s1_val = '0;
            endcase
        end
        // stage two: the answer, straight from flops
        next_st.out_valid = st.s1_valid;
        next_st.out_fault_valid = st.s1_valid && st.s1_fault != arsa_pkg::FLT_NONE;
        next_st.out_fault = st.s1_fault;
        next_st.out_tag = 1'b0;
        case (st.s1_src)
            arsa_pkg::SRC_INT: begin
                next_st.out_data = {18'h00000, int_if.rdata[`ARSA_DATA_W-1:0]};
                next_st.out_tag = int_if.rdata[`ARSA_INT_TAG_BIT];
            end
            arsa_pkg::SRC_FLT: next_st.out_data = flt_if.rdata;
            default: next_st.out_data = st.s1_val;
        endcase
        // small register writes, only without a fault
        if (commit) begin
            case (req_file)
                arsa_pkg::FILE_PRD: begin
                    // predicate 0 result is silently thrown away
                    if (req_index != 7'h00) next_st.pred[req_index[5:0]] = req_wdata[0];
                end
                arsa_pkg::FILE_BRR: next_st.br[req_index[2:0]] = req_wdata[63:0];
                arsa_pkg::FILE_APP: begin
                    // ignored register: write accepted and dropped
                    if (req_index == `ARSA_APP_CTRL) next_st.mode = req_wdata[1:0];
                end
                default: next_st.mode = st.mode;
            endcase
        end
        if (req_valid && fault != arsa_pkg::FLT_NONE) begin
            next_st.fault_count = st.fault_count + 16'h0001;
        end
        // native bundles are 16-byte aligned; legacy keeps the byte address
        if (ip_load) begin
            next_st.ip = ip_target;
            if (!ip_legacy) next_st.ip[`ARSA_BUNDLE_LSBS-1:0] = 4'h0;
        end
        if (rst) begin
            next_st = '0;
            next_st.mode = `ARSA_MODE_RESET;
            next_st.ip = `ARSA_IP_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    // outputs come straight from state flops
    assign rsp_valid = st.out_valid;
    assign rsp_rdata = st.out_data;
    assign rsp_tag = st.out_tag;
    assign fault_valid = st.out_fault_valid;
    assign fault_code = st.out_fault;
    assign ip_value = st.ip;

    // ======================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_resv_reg;
        req_valid && !req_legacy && req_file == arsa_pkg::FILE_APP && req_index >= 7'h08
        |-> ##2 fault_valid && fault_code == arsa_pkg::FLT_ILLOP;
    endproperty
    a_resv_reg: assert property (p_resv_reg) else $error("reserved register no fault");
    property p_ign_reg;
        req_valid && !req_legacy && req_file == arsa_pkg::FILE_APP && req_index == 7'h00
        |-> ##2 rsp_valid && !fault_valid && rsp_rdata == '0;
    endproperty
    a_ign_reg: assert property (p_ign_reg) else $error("ignored register misbehaved");
    property p_unimpl;
        req_valid && !req_legacy && req_file == arsa_pkg::FILE_APP &&
        req_index >= 7'h03 && req_index <= 7'h07 |-> ##2 fault_code == arsa_pkg::FLT_RESFLD;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented entry no fault");
    property p_ctrl_read;
        req_valid && !req_write && !req_legacy && req_file == arsa_pkg::FILE_APP &&
        req_index == 7'h01 |-> ##2 rsp_rdata[81:2] == '0 && rsp_rdata[1:0] != 2'h3;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("field bits read nonzero");
    property p_rsv_write;
        req_valid && req_write && !req_legacy && req_file == arsa_pkg::FILE_APP &&
        req_index == 7'h01 && (req_wdata[7:4] != 4'h0 || req_wdata[1:0] == 2'h3)
        |=> $stable(st.mode) ##1 fault_valid && fault_code == arsa_pkg::FLT_RESFLD;
    endproperty
    a_rsv_write: assert property (p_rsv_write) else $error("reserved write accepted");
    property p_ro_write;
        req_valid && req_write && req_file == arsa_pkg::FILE_IPR && !ip_load
        |=> $stable(ip_value) ##1 fault_code == arsa_pkg::FLT_ILLOP;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");
    property p_ip_native;
        ip_load && !ip_legacy |=> ip_value == {$past(ip_target[63:4]), 4'h0};
    endproperty
    a_ip_native: assert property (p_ip_native) else $error("bundle address misaligned");
    property p_legacy;
        req_valid && req_legacy && req_file != arsa_pkg::FILE_INT &&
        req_file != arsa_pkg::FILE_FLT |-> ##2 fault_code == arsa_pkg::FLT_ILLOP;
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy reached native state");
    property p_int_zero;
        req_valid && !req_write && req_file == arsa_pkg::FILE_INT && req_index == 7'h00
        |-> ##2 rsp_rdata == '0;
    endproperty
    a_int_zero: assert property (p_int_zero) else $error("integer entry 0 not zero");
    property p_fp_one;
        req_valid && !req_write && !req_legacy && req_file == arsa_pkg::FILE_FLT &&
        req_index == 7'h01 |-> ##2 rsp_rdata == `ARSA_FP_ONE;
    endproperty
    a_fp_one: assert property (p_fp_one) else $error("float entry 1 not one");
    property p_pred_zero;
        req_valid && !req_write && !req_legacy && req_file == arsa_pkg::FILE_PRD &&
        req_index == 7'h00 |-> ##2 rsp_rdata[0] && !fault_valid;
    endproperty
    a_pred_zero: assert property (p_pred_zero) else $error("predicate 0 not one");
    property p_fault_match;
        req_valid |-> ##2 fault_valid == (access_fault($past(req_file, 2), $past(req_index, 2),
            $past(req_write, 2), $past(req_wdata, 2), $past(req_legacy, 2)) != arsa_pkg::FLT_NONE);
    endproperty
    a_fault_match: assert property (p_fault_match) else $error("fault not reported");

    c_int_rw: cover property (req_valid && req_write && req_file == arsa_pkg::FILE_INT
        ##1 req_valid && !req_write && req_file == arsa_pkg::FILE_INT);
    c_resfld: cover property (fault_valid && fault_code == arsa_pkg::FLT_RESFLD);
    c_illop: cover property (fault_valid && fault_code == arsa_pkg::FLT_ILLOP);
    c_legacy_ok: cover property (req_valid && req_legacy && fault == arsa_pkg::FLT_NONE);
endmodule // arsa_regstate

/* File: tb/arsa_pipe_model.sv */
// arsa_pipe_model: pipeline side; issues requests, logs answers.
// assumes: arsa_pkg compiled first, mclk shared.
`include "arsa_map.svh"
module arsa_pipe_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // access request
    output logic req_valid,
    output logic req_write,
    output arsa_pkg::arsa_file_e req_file,
    output logic [`ARSA_IDX_W-1:0] req_index,
    output logic [`ARSA_FLT_W-1:0] req_wdata,
    output logic req_wtag,
    output logic req_legacy,
    // instruction pointer update
    output logic ip_load,
    output logic ip_legacy,
    output logic [`ARSA_DATA_W-1:0] ip_target,
    // answer and fault
    input wire logic rsp_valid,
    input wire logic [`ARSA_FLT_W-1:0] rsp_rdata,
    input wire logic rsp_tag,
    input wire logic fault_valid,
    input wire arsa_pkg::arsa_fault_e fault_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // answer log: {data, tag, fault flag, fault code}
    logic [85:0] answers[$];
    logic [1:0] taken = 2'h0;
    int late = 0;

    // quiet lines at time zero
    initial begin
        {req_valid, req_write, req_wtag, req_legacy, ip_load, ip_legacy} = '0;
        {req_index, req_wdata, ip_target} = '0;
        req_file = arsa_pkg::FILE_INT;
    end

    // answer lands two edges after its taking edge, nowhere else
    always @(posedge mclk) begin
        taken <= {taken[0], req_valid & ~rst};
        if (!rst) begin
            if (rsp_valid !== taken[1] || (fault_valid === 1'b1 && rsp_valid !== 1'b1))
                late++;
            if (rsp_valid === 1'b1)
                answers.push_back({rsp_rdata, rsp_tag, fault_valid, fault_code});
        end
    end

    // ======================================================================
    // one request for one edge; returns at the taking edge
    task automatic send(input logic wr, input arsa_pkg::arsa_file_e f,
            input logic [`ARSA_IDX_W-1:0] idx, input logic [`ARSA_FLT_W-1:0] wd,
            input logic tag, input logic leg);
        req_valid <= 1'b1;
        req_write <= wr;
        req_file <= f;
        req_index <= idx;
        req_wdata <= wd;
        req_wtag <= tag;
        req_legacy <= leg;
        @(posedge mclk);
    endtask

    // released lines flip so stale values never pass as a request
    task automatic idle();
        req_valid <= 1'b0;
        req_write <= ~req_write;
        req_index <= ~req_index;
        req_wdata <= ~req_wdata;
        req_wtag <= ~req_wtag;
        req_legacy <= ~req_legacy;
    endtask

    // pointer load pulse of one edge
    task automatic load_ip(input logic leg, input logic [`ARSA_DATA_W-1:0] tgt);
        ip_load <= 1'b1;
        ip_legacy <= leg;
        ip_target <= tgt;
        @(posedge mclk);
        ip_load <= 1'b0;
        ip_legacy <= ~leg;
        ip_target <= ~tgt;
    endtask
endmodule // arsa_pipe_model

/* File: tb/test_app_register_state_access_policy.sv */
// test_app_register_state_access_policy: bench of the register block.
// assumes: design and pipe model compiled first.
`include "arsa_map.svh"
module test_app_register_state_access_policy;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // nets and bookkeeping
    localparam arsa_pkg::arsa_file_e f_int = arsa_pkg::FILE_INT;
    localparam arsa_pkg::arsa_file_e f_flt = arsa_pkg::FILE_FLT;
    localparam arsa_pkg::arsa_file_e f_prd = arsa_pkg::FILE_PRD;
    localparam arsa_pkg::arsa_file_e f_brr = arsa_pkg::FILE_BRR;
    localparam arsa_pkg::arsa_file_e f_ipr = arsa_pkg::FILE_IPR;
    localparam arsa_pkg::arsa_file_e f_app = arsa_pkg::FILE_APP;
    localparam arsa_pkg::arsa_fault_e k_ok = arsa_pkg::FLT_NONE;
    localparam arsa_pkg::arsa_fault_e k_ill = arsa_pkg::FLT_ILLOP;
    localparam arsa_pkg::arsa_fault_e k_res = arsa_pkg::FLT_RESFLD;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req_valid, req_write, req_wtag, req_legacy, ip_load, ip_legacy;
    arsa_pkg::arsa_file_e req_file;
    logic [`ARSA_IDX_W-1:0] req_index;
    logic [`ARSA_FLT_W-1:0] req_wdata, rsp_rdata;
    logic [`ARSA_DATA_W-1:0] ip_target, ip_value;
    logic rsp_valid, rsp_tag, fault_valid;
    arsa_pkg::arsa_fault_e fault_code;
    int failures = 0;
    int comparisons = 0;
    int nflt = 0;
    logic leg = 1'b0;

    // 40 MHz core clock
    always #12.5 mclk = ~mclk;

    arsa_regstate u_arsa_regstate (.*);
    arsa_pipe_model u_arsa_pipe_model (.*);

    // ======================================================================
    // shared comparison and transfer tasks
    task automatic check(input string what, input logic [81:0] exp, input logic [81:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // no answer reads as all ones, so its data never matches
    task automatic judge(input string what, input logic [81:0] rd, input logic tg,
            input arsa_pkg::arsa_fault_e fc);
        logic [85:0] a;
        a = '1;
        if (u_arsa_pipe_model.answers.size() > 0)
            a = u_arsa_pipe_model.answers.pop_front();
        check({what, " data"}, rd, a[85:4]);
        check({what, " tag"}, 82'(tg), 82'(a[3]));
        check({what, " fault"}, 82'(fc != k_ok), 82'(a[2]));
        if (fc != k_ok) begin
            nflt++;
            check({what, " code"}, 82'(fc), 82'(a[1:0]));
        end
    endtask

    // one request, judged after its answer lands
    task automatic xact(input string what, input logic wr, input arsa_pkg::arsa_file_e f,
            input int idx, input logic [81:0] wd, input logic [81:0] rd, input logic tg,
            input arsa_pkg::arsa_fault_e fc);
        u_arsa_pipe_model.send(wr, f, 7'(idx), wd, tg, leg);
        u_arsa_pipe_model.idle();
        repeat (3) @(posedge mclk);
        judge(what, rd, wr ? 1'b0 : tg, fc);
    endtask

    task automatic wq(input string what, input arsa_pkg::arsa_file_e f, input int idx,
            input logic [81:0] wd, input logic tag, input arsa_pkg::arsa_fault_e fc);
        xact(what, 1'b1, f, idx, wd, 82'h0, tag, fc);
    endtask

    task automatic rq(input string what, input arsa_pkg::arsa_file_e f, input int idx,
            input logic [81:0] rd, input logic tg, input arsa_pkg::arsa_fault_e fc);
        xact(what, 1'b0, f, idx, 82'h0, rd, tg, fc);
    endtask

    // ======================================================================
    // scenarios
    // write then read the same entry on back-to-back edges
    task automatic t_int();
        u_arsa_pipe_model.send(1'b1, f_int, 7'h09, 82'hABCD0123456789ABCDEF, 1'b1, 1'b0);
        u_arsa_pipe_model.send(1'b0, f_int, 7'h09, 82'h0, 1'b0, 1'b0);
        u_arsa_pipe_model.idle();
        repeat (3) @(posedge mclk);
        judge("int 9 write", 82'h0, 1'b0, k_ok);
        judge("int 9 read", 82'h0123456789ABCDEF, 1'b1, k_ok);
        wq("int 127 write", f_int, 127, 82'hFEDCBA9876543210, 1'b0, k_ok);
        rq("int 127 read", f_int, 127, 82'hFEDCBA9876543210, 1'b0, k_ok);
        wq("int 0 write", f_int, 0, 82'h5, 1'b0, k_ill);
        rq("int 0 read", f_int, 0, 82'h0, 1'b0, k_ok);
    endtask

    task automatic t_flt();
        rq("flt 0", f_flt, 0, `ARSA_FP_ZERO, 1'b0, k_ok);
        rq("flt 1", f_flt, 1, `ARSA_FP_ONE, 1'b0, k_ok);
        wq("flt 0 write", f_flt, 0, 82'h1, 1'b0, k_ill);
        wq("flt 1 write", f_flt, 1, 82'h2, 1'b0, k_ill);
        rq("flt 1 kept", f_flt, 1, `ARSA_FP_ONE, 1'b0, k_ok);
        wq("flt 127 write", f_flt, 127, 82'h2AAAA55555AAAA5555AAA, 1'b0, k_ok);
        rq("flt 127 read", f_flt, 127, 82'h2AAAA55555AAAA5555AAA, 1'b0, k_ok);
    endtask

    task automatic t_prd_brr();
        wq("prd 63 write", f_prd, 63, 82'h1, 1'b0, k_ok);
        rq("prd 63 read", f_prd, 63, 82'h1, 1'b0, k_ok);
        wq("prd 0 write", f_prd, 0, 82'h0, 1'b0, k_ok);
        rq("prd 0 read", f_prd, 0, 82'h1, 1'b0, k_ok);
        rq("prd 64", f_prd, 64, 82'h0, 1'b0, k_ill);
        wq("brr 7 write", f_brr, 7, 82'h0000FEEDFACE12345678, 1'b0, k_ok);
        rq("brr 7 read", f_brr, 7, 82'h0000FEEDFACE12345678, 1'b0, k_ok);
        wq("brr 8 write", f_brr, 8, 82'h7, 1'b0, k_ill);
    endtask

    task automatic t_ip();
        u_arsa_pipe_model.load_ip(1'b0, 64'h0000000000001237);
        #1;
        check("ip bundle", 82'h1230, 82'(ip_value));
        @(posedge mclk);
        rq("ipr read", f_ipr, 0, 82'h1230, 1'b0, k_ok);
        wq("ipr write", f_ipr, 0, 82'h4440, 1'b0, k_ill);
        rq("ipr 1", f_ipr, 1, 82'h0, 1'b0, k_ill);
        check("ip kept", 82'h1230, 82'(ip_value));
        u_arsa_pipe_model.load_ip(1'b1, 64'hFEDCBA9876543217);
        #1;
        check("ip byte", 82'hFEDCBA9876543217, 82'(ip_value));
        @(posedge mclk);
    endtask

    task automatic t_app();
        wq("app 0 write", f_app, 0, 82'h3FFFFFFFFFFFFFFFFFFFF, 1'b0, k_ok);
        rq("app 0 read", f_app, 0, 82'h0, 1'b0, k_ok);
        rq("app 3", f_app, 3, 82'h0, 1'b0, k_res);
        wq("app 7", f_app, 7, 82'h1, 1'b0, k_res);
        rq("app 8", f_app, 8, 82'h0, 1'b0, k_ill);
        wq("ctrl mode", f_app, 1, 82'hE, 1'b0, k_ok);
        rq("ctrl read", f_app, 1, 82'h2, 1'b0, k_ok);
        wq("ctrl rsv bit", f_app, 1, 82'h11, 1'b0, k_res);
        wq("ctrl rsv top", f_app, 1, 82'h20000000000000000001, 1'b0, k_res);
        wq("ctrl rsv mode", f_app, 1, 82'h3, 1'b0, k_res);
        rq("ctrl kept", f_app, 1, 82'h2, 1'b0, k_ok);
        wq("stat write", f_app, 2, 82'h0, 1'b0, k_ill);
        rq("stat count", f_app, 2, 82'(nflt[15:0]), 1'b0, k_ok);
    endtask

    // legacy reaches only integer and float entries 8..31
    task automatic t_leg();
        leg = 1'b1;
        wq("leg int 8", f_int, 8, 82'h0000000087654321, 1'b0, k_ok);
        rq("leg int 8 read", f_int, 8, 82'h0000000087654321, 1'b0, k_ok);
        wq("leg flt 31", f_flt, 31, 82'h1234, 1'b0, k_ok);
        rq("leg flt 31 read", f_flt, 31, 82'h1234, 1'b0, k_ok);
        rq("leg int 7", f_int, 7, 82'h0, 1'b0, k_ill);
        rq("leg int 32", f_int, 32, 82'h0, 1'b0, k_ill);
        rq("leg flt 32", f_flt, 32, 82'h0, 1'b0, k_ill);
        rq("leg brr 0", f_brr, 0, 82'h0, 1'b0, k_ill);
        rq("leg app 1", f_app, 1, 82'h0, 1'b0, k_ill);
        leg = 1'b0;
        rq("file 6", arsa_pkg::arsa_file_e'(3'h6), 0, 82'h0, 1'b0, k_ill);
        wq("file 7", arsa_pkg::arsa_file_e'(3'h7), 0, 82'h1, 1'b0, k_ill);
    endtask

    // ======================================================================
    // verdict, main sequence and watchdog
    task automatic conclude();
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_int();
        t_flt();
        t_prd_brr();
        t_ip();
        t_app();
        t_leg();
        check("answer timing", 82'h0, 82'(u_arsa_pipe_model.late));
        conclude();
    end

    // run needs a few hundred cycles; ample slack
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        conclude();
    end
endmodule // test_app_register_state_access_policy
